// >>> rtl/slc_regs.sv
// Control register bank for the speaker class, boost and line output anti-pop controls.
`timescale 1ns/1ps

module slc_regs (
  input  wire logic                      clock,
  input  wire logic                      reset_n,
  input  wire logic                      reg_write,
  input  wire logic                      reg_read,
  input  wire logic [7:0]                reg_addr,
  input  wire logic [7:0]                reg_wdata,
  output logic      [7:0]                reg_rdata,
  output logic                           reg_rdata_valid,
  input  wire logic                      line_output_enable,
  input  wire logic                      speaker_enable,
  output slc_pkg::slc_speaker_ctrl_t     speaker_ctrl,
  output slc_pkg::slc_line_ctrl_t        line_ctrl,
  output logic                           boost_write_while_enabled
);
  import slc_pkg::*;

  // ---------------------------------------------------------------------------
  // Address decode helpers
  // ---------------------------------------------------------------------------

  // True when the address names one of the four registers of this bank.
  // Only exact matches count, so no register shows up at an alias address.
  function automatic logic is_mapped(input logic [7:0] addr);
    is_mapped = (addr == MIDRAIL_BUFFER_CONTROL_ADDR) ||
                (addr == ANTIPOP_LINE_CONTROL_ADDR)   ||
                (addr == SPEAKER_BOOST_CONTROL_ADDR)  ||
                (addr == SPEAKER_CLASS_CONTROL_ADDR);
  endfunction

  // Write strobe for a given register, used once per register below.
  function automatic logic write_hit(input logic       wr,
                                     input logic [7:0] addr,
                                     input logic [7:0] target);
    write_hit = wr && (addr == target);
  endfunction

  // ---------------------------------------------------------------------------
  // Stored fields
  // ---------------------------------------------------------------------------
  logic       midrail_buffer_enable_reg;
  logic       line_output_clamp_reg;
  logic       clamp_resistance_select_reg;
  logic       line_output_discharge_reg;
  logic [2:0] speaker_dc_boost_reg;
  logic [2:0] speaker_ac_boost_reg;
  logic       speaker_class_select_reg;

  logic       wr_midrail;
  logic       wr_antipop;
  logic       wr_boost;
  logic       wr_class;

  // Per-register write strobes. A write to any other address hits none of them,
  // so it is dropped without any sign on the bus.
  assign wr_midrail = write_hit(reg_write, reg_addr, MIDRAIL_BUFFER_CONTROL_ADDR);
  assign wr_antipop = write_hit(reg_write, reg_addr, ANTIPOP_LINE_CONTROL_ADDR);
  assign wr_boost   = write_hit(reg_write, reg_addr, SPEAKER_BOOST_CONTROL_ADDR);
  assign wr_class   = write_hit(reg_write, reg_addr, SPEAKER_CLASS_CONTROL_ADDR);

  // buffer enable store
  // Midrail buffer enable, off after reset.
  // The clamp below cannot connect until this buffer is running.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      midrail_buffer_enable_reg <= MIDRAIL_BUFFER_ENABLE_RST;
    end else if (wr_midrail) begin
      midrail_buffer_enable_reg <= reg_wdata[MIDRAIL_BUFFER_ENABLE_BIT];
    end
  end

  // clamp bit store
  // Line clamp request and its resistance choice share the anti-pop register.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      line_output_clamp_reg       <= LINE_OUTPUT_CLAMP_RST;
      clamp_resistance_select_reg <= CLAMP_RESISTANCE_SELECT_RST;
    end else if (wr_antipop) begin
      line_output_clamp_reg       <= reg_wdata[LINE_OUTPUT_CLAMP_BIT];
      clamp_resistance_select_reg <= reg_wdata[CLAMP_RESISTANCE_SELECT_BIT];
    end
  end

  // discharge store
  // Discharge stays asserted until software writes it back to zero.
  // It has no interlock with the clamp; software chooses the order of the two.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      line_output_discharge_reg <= LINE_OUTPUT_DISCHARGE_RST;
    end else if (wr_antipop) begin
      line_output_discharge_reg <= reg_wdata[LINE_OUTPUT_DISCHARGE_BIT];
    end
  end

  // ac boost store
  // Reserved codes are stored as written so that they read back unchanged;
  // only the decoder downstream treats them specially.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      speaker_dc_boost_reg <= SPEAKER_DC_BOOST_RST;
      speaker_ac_boost_reg <= SPEAKER_AC_BOOST_RST;
    end else if (wr_boost) begin
      speaker_dc_boost_reg <= reg_wdata[DC_BOOST_MSB:DC_BOOST_LSB];
      speaker_ac_boost_reg <= reg_wdata[AC_BOOST_MSB:AC_BOOST_LSB];
    end
  end

  // class select store
  // Class D after reset; a written one moves the driver to class AB.
  // The change reaches speaker_ctrl one cycle later through the output register; no speaker sequencing is applied here.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      speaker_class_select_reg <= SPEAKER_CLASS_SELECT_RST;
    end else if (wr_class) begin
      speaker_class_select_reg <= reg_wdata[SPEAKER_CLASS_SELECT_BIT];
    end
  end

  // ---------------------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------------------
  logic [7:0] rdata_next;

  // readback image
  // Each register image carries only its described fields; all else is zero.
  // Reads have no side effects, so a repeated read returns the same image.
  always_comb begin
    rdata_next = 8'h00;
    if (is_mapped(reg_addr)) begin
      case (reg_addr)
        MIDRAIL_BUFFER_CONTROL_ADDR: begin
          rdata_next[MIDRAIL_BUFFER_ENABLE_BIT] = midrail_buffer_enable_reg;
        end
        ANTIPOP_LINE_CONTROL_ADDR: begin
          rdata_next[LINE_OUTPUT_CLAMP_BIT]       = line_output_clamp_reg;
          rdata_next[CLAMP_RESISTANCE_SELECT_BIT] = clamp_resistance_select_reg;
          rdata_next[LINE_OUTPUT_DISCHARGE_BIT]   = line_output_discharge_reg;
        end
        SPEAKER_BOOST_CONTROL_ADDR: begin
          rdata_next[DC_BOOST_MSB:DC_BOOST_LSB] = speaker_dc_boost_reg;
          rdata_next[AC_BOOST_MSB:AC_BOOST_LSB] = speaker_ac_boost_reg;
        end
        SPEAKER_CLASS_CONTROL_ADDR: begin
          rdata_next[SPEAKER_CLASS_SELECT_BIT] = speaker_class_select_reg;
        end
        default: begin
          rdata_next = 8'h00;
        end
      endcase
    end
  end

  // Read data is captured one cycle after the read strobe and then held,
  // so the bus side may sample it at its leisure.
  // A read and a write in the same cycle return the contents before the write.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      reg_rdata <= rdata_next;
    end
  end

  // One-cycle marker that fresh read data stands on the data port.
  // Back-to-back reads give one marker per read with no gap between them.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata_valid <= 1'b0;
    end else begin
      reg_rdata_valid <= reg_read;
    end
  end

  // ---------------------------------------------------------------------------
  // Boost decode and clamp gating
  // ---------------------------------------------------------------------------
  logic [BOOST_LEVELS-1:0] dc_level;
  logic [BOOST_LEVELS-1:0] ac_level;
  logic                    dc_reserved;
  logic                    ac_reserved;
  logic                    clamp_active;
  logic                    clamp_low_path;
  logic                    clamp_high_path;

  // Both fields use the same decoder module so their code mapping cannot drift apart.
  // dc level decode
  slc_boost_decode u_dc_decode (
    .code      (speaker_dc_boost_reg),
    .level_sel (dc_level),
    .reserved  (dc_reserved)
  );

  slc_boost_decode u_ac_decode (
    .code      (speaker_ac_boost_reg),
    .level_sel (ac_level),
    .reserved  (ac_reserved)
  );

  // The line enable comes from logic on this clock and needs no synchroniser.
  // clamp gating
  slc_clamp_gate u_clamp (
    .clamp_request           (line_output_clamp_reg),
    .clamp_resistance_select (clamp_resistance_select_reg),
    .midrail_buffer_enable   (midrail_buffer_enable_reg),
    .line_output_enable      (line_output_enable),
    .clamp_active            (clamp_active),
    .low_path                (clamp_low_path),
    .high_path               (clamp_high_path)
  );

  // ---------------------------------------------------------------------------
  // Analogue control outputs
  // ---------------------------------------------------------------------------
  slc_speaker_ctrl_t speaker_ctrl_next;
  slc_line_ctrl_t    line_ctrl_next;

  // Bundle the decoded speaker controls.
  // A reserved code on either field is reported on one shared flag.
  always_comb begin
    speaker_ctrl_next.speaker_class_select = slc_class_t'(speaker_class_select_reg);
    speaker_ctrl_next.speaker_dc_boost     = dc_level;
    speaker_ctrl_next.speaker_ac_boost     = ac_level;
    speaker_ctrl_next.boost_code_reserved  = dc_reserved | ac_reserved;
  end

  // Bundle the line output controls.
  // Both resistance paths are offered so the driver needs no decode of its own.
  always_comb begin
    line_ctrl_next.midrail_buffer_enable = midrail_buffer_enable_reg;
    line_ctrl_next.clamp_to_midrail      = clamp_active;
    line_ctrl_next.clamp_low_resistance  = clamp_low_path;
    line_ctrl_next.clamp_high_resistance = clamp_high_path;
    line_ctrl_next.line_output_discharge = line_output_discharge_reg;
  end

  // class and boost out
  // Registered so the analogue side never sees decode glitches; the cost is
  // one cycle of latency after a write, well below any audible scale.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      speaker_ctrl.speaker_class_select <= slc_class_t'(SPEAKER_CLASS_SELECT_RST);
      speaker_ctrl.speaker_dc_boost     <= BOOST_LEVELS'(1) << SPEAKER_DC_BOOST_RST;
      speaker_ctrl.speaker_ac_boost     <= BOOST_LEVELS'(1) << SPEAKER_AC_BOOST_RST;
      speaker_ctrl.boost_code_reserved  <= 1'b0;
    end else begin
      speaker_ctrl <= speaker_ctrl_next;
    end
  end

  // discharge out
  // Line controls, including the discharge pull, registered toward the driver.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      line_ctrl.midrail_buffer_enable <= MIDRAIL_BUFFER_ENABLE_RST;
      line_ctrl.clamp_to_midrail      <= 1'b0;
      line_ctrl.clamp_low_resistance  <= 1'b0;
      line_ctrl.clamp_high_resistance <= 1'b0;
      line_ctrl.line_output_discharge <= LINE_OUTPUT_DISCHARGE_RST;
    end else begin
      line_ctrl <= line_ctrl_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Pop hazard indication
  // ---------------------------------------------------------------------------
  logic boost_changes;

  // A boost write only counts when it actually alters a stored code.
  // Rewriting the same codes is silent, so software may refresh the register.
  assign boost_changes = wr_boost &&
    ((reg_wdata[DC_BOOST_MSB:DC_BOOST_LSB] != speaker_dc_boost_reg) ||
     (reg_wdata[AC_BOOST_MSB:AC_BOOST_LSB] != speaker_ac_boost_reg));

  // pop hazard flag
  // The write is still honoured; this pulse only lets the system see that
  // the speaker was live when its boost moved, which is likely to pop.
  // The pulse is not held; a system that counts hazards must watch every cycle.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      boost_write_while_enabled <= 1'b0;
    end else begin
      boost_write_while_enabled <= boost_changes & speaker_enable;
    end
  end

endmodule

// >>> rtl/slc_pkg.sv
// Package of offsets, field layouts, reset values and carriers for the speaker/line control bank.
package slc_pkg;

  // ---------------------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] MIDRAIL_BUFFER_CONTROL_ADDR = 8'h04;
  localparam logic [7:0] ANTIPOP_LINE_CONTROL_ADDR   = 8'h08;
  localparam logic [7:0] SPEAKER_BOOST_CONTROL_ADDR  = 8'h09;
  localparam logic [7:0] SPEAKER_CLASS_CONTROL_ADDR  = 8'h0a;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int MIDRAIL_BUFFER_ENABLE_BIT   = 5;
  localparam int LINE_OUTPUT_CLAMP_BIT       = 0;
  localparam int CLAMP_RESISTANCE_SELECT_BIT = 1;
  localparam int LINE_OUTPUT_DISCHARGE_BIT   = 2;
  localparam int DC_BOOST_MSB                = 5;
  localparam int DC_BOOST_LSB                = 3;
  localparam int AC_BOOST_MSB                = 2;
  localparam int AC_BOOST_LSB                = 0;
  localparam int SPEAKER_CLASS_SELECT_BIT    = 6;

  // ---------------------------------------------------------------------------
  // Reset values and boost codes
  // ---------------------------------------------------------------------------
  localparam logic       MIDRAIL_BUFFER_ENABLE_RST   = 1'b0;
  localparam logic       LINE_OUTPUT_CLAMP_RST       = 1'b0;
  localparam logic       CLAMP_RESISTANCE_SELECT_RST = 1'b0;
  localparam logic       LINE_OUTPUT_DISCHARGE_RST   = 1'b0;
  localparam logic       SPEAKER_CLASS_SELECT_RST    = 1'b0;
  localparam logic [2:0] SPEAKER_DC_BOOST_RST        = 3'h3;
  localparam logic [2:0] SPEAKER_AC_BOOST_RST        = 3'h3;
  localparam logic [2:0] BOOST_CODE_MAX              = 3'h5;
  localparam int         BOOST_LEVELS                = 6;

  // Speaker class encodings.
  typedef enum logic {
    SLC_CLASS_D  = 1'b0,
    SLC_CLASS_AB = 1'b1
  } slc_class_t;

  // Controls handed to the analogue speaker driver.
  typedef struct packed {
    slc_class_t                    speaker_class_select;
    logic [BOOST_LEVELS-1:0]       speaker_dc_boost;
    logic [BOOST_LEVELS-1:0]       speaker_ac_boost;
    logic                          boost_code_reserved;
  } slc_speaker_ctrl_t;

  // Controls handed to the analogue line output driver.
  typedef struct packed {
    logic midrail_buffer_enable;
    logic clamp_to_midrail;
    logic clamp_low_resistance;
    logic clamp_high_resistance;
    logic line_output_discharge;
  } slc_line_ctrl_t;

endpackage

// >>> rtl/slc_boost_decode.sv
// One-hot decoder from a three-bit speaker boost code to the six boost levels.
`timescale 1ns/1ps

module slc_boost_decode (
  input  wire logic [2:0]                      code,
  output logic      [slc_pkg::BOOST_LEVELS-1:0] level_sel,
  output logic                                 reserved
);
  import slc_pkg::*;

  // ---------------------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------------------

  // ascending level order
  // Code n lights level n; a reserved code falls back to unity so the
  // amplifier never sees an undefined gain setting.
  always_comb begin
    level_sel = '0;
    reserved  = 1'b0;
    if (code > BOOST_CODE_MAX) begin
      level_sel[0] = 1'b1;
      reserved     = 1'b1;
    end else begin
      level_sel[code] = 1'b1;
    end
  end

endmodule

// >>> rtl/slc_clamp_gate.sv
// Gating of the disabled line output clamp and its resistance path.
`timescale 1ns/1ps

module slc_clamp_gate (
  input  wire logic clamp_request,
  input  wire logic clamp_resistance_select,
  input  wire logic midrail_buffer_enable,
  input  wire logic line_output_enable,
  output logic      clamp_active,
  output logic      low_path,
  output logic      high_path
);

  // ---------------------------------------------------------------------------
  // Clamp qualification
  // ---------------------------------------------------------------------------

  // clamp qualified
  // The clamp only connects while the line driver is off and the buffer runs.
  assign clamp_active = clamp_request & ~line_output_enable & midrail_buffer_enable;

  // resistance path
  // The resistance choice has no effect unless the clamp is connected.
  assign low_path  = clamp_active & clamp_resistance_select;
  assign high_path = clamp_active & ~clamp_resistance_select;

endmodule

// >>> test/slc_regs_assertions.sv
// Concurrent checks on the ports of the speaker and line control bank.
`timescale 1ns/1ps

module slc_regs_assertions
  import slc_pkg::*;
(
  input wire logic                       clock,
  input wire logic                       reset_n,
  input wire logic                       reg_write,
  input wire logic                       reg_read,
  input wire logic [7:0]                 reg_addr,
  input wire logic [7:0]                 reg_wdata,
  input wire logic [7:0]                 reg_rdata,
  input wire logic                       reg_rdata_valid,
  input wire logic                       line_output_enable,
  input wire logic                       speaker_enable,
  input wire slc_pkg::slc_speaker_ctrl_t speaker_ctrl,
  input wire slc_pkg::slc_line_ctrl_t    line_ctrl,
  input wire logic                       boost_write_while_enabled
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);

  // A write to one place followed by a cycle without another write there.
  sequence s_wr(a);
    reg_write && reg_addr == a ##1 !(reg_write && reg_addr == a);
  endsequence

  a_read_latency:
    assert property (reg_rdata_valid == $past(reg_read)) else $error("read valid misplaced");
  a_rdata_hold:
    assert property (!reg_read |=> $stable(reg_rdata)) else $error("read data moved");
  a_unmapped_zero:
    assert property (reg_read && !(reg_addr inside {8'h04, 8'h08, 8'h09, 8'h0a})
      |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  a_class_follow:
    assert property (s_wr(SPEAKER_CLASS_CONTROL_ADDR)
      |=> speaker_ctrl.speaker_class_select == $past(reg_wdata[6], 2))
      else $error("class select wrong");
  a_midrail_follow:
    assert property (s_wr(MIDRAIL_BUFFER_CONTROL_ADDR)
      |=> line_ctrl.midrail_buffer_enable == $past(reg_wdata[5], 2))
      else $error("buffer enable wrong");
  a_discharge_follow:
    assert property (s_wr(ANTIPOP_LINE_CONTROL_ADDR)
      |=> line_ctrl.line_output_discharge == $past(reg_wdata[2], 2))
      else $error("discharge wrong");
  a_boost_onehot:
    assert property ($onehot(speaker_ctrl.speaker_dc_boost)
      && $onehot(speaker_ctrl.speaker_ac_boost)) else $error("boost not one-hot");
  a_dc_decode:
    assert property (s_wr(SPEAKER_BOOST_CONTROL_ADDR) |=> speaker_ctrl.speaker_dc_boost ==
      ($past(reg_wdata[5:3], 2) > 3'h5 ? 6'h01 : 6'h01 << $past(reg_wdata[5:3], 2)))
      else $error("dc boost decode wrong");
  a_clamp_gate:
    assert property (line_ctrl.clamp_to_midrail
      |-> !$past(line_output_enable) && line_ctrl.midrail_buffer_enable)
      else $error("clamp while not allowed");
  a_clamp_path:
    assert property (line_ctrl.clamp_to_midrail == (line_ctrl.clamp_low_resistance
      ^ line_ctrl.clamp_high_resistance)
      && !(line_ctrl.clamp_low_resistance && line_ctrl.clamp_high_resistance))
      else $error("clamp path wrong");
  a_boost_flag:
    assert property (boost_write_while_enabled |-> $past(reg_write) && $past(speaker_enable)
      && $past(reg_addr) == SPEAKER_BOOST_CONTROL_ADDR) else $error("stray boost flag");
endmodule

bind slc_regs slc_regs_assertions u_slc_chk (
  .clock, .reset_n, .reg_write, .reg_read, .reg_addr, .reg_wdata, .reg_rdata,
  .reg_rdata_valid, .line_output_enable, .speaker_enable, .speaker_ctrl, .line_ctrl,
  .boost_write_while_enabled
);

// >>> test/slc_analog_model.sv
// Behavioural view of the analogue speaker and line drivers fed by the bank.
`timescale 1ns/1ps

module slc_analog_model
  import slc_pkg::*;
(
  input  wire slc_pkg::slc_speaker_ctrl_t speaker_ctrl,
  input  wire slc_pkg::slc_line_ctrl_t    line_ctrl,
  input  wire logic                       line_output_enable,
  output logic      [2:0]                 dc_level,
  output logic      [2:0]                 ac_level,
  output logic                            class_ab,
  output logic      [1:0]                 line_pin
);
  // Anything but a clean one-hot reads as level 7, which no code may give.
  function automatic logic [2:0] level_of(input logic [5:0] sel);
    level_of = 3'h7;
    for (int i = 0; i < 6; i++) begin
      if (sel === 6'h01 << i) level_of = 3'(i);
    end
  endfunction

  assign dc_level = level_of(speaker_ctrl.speaker_dc_boost);
  assign ac_level = level_of(speaker_ctrl.speaker_ac_boost);
  assign class_ab = speaker_ctrl.speaker_class_select == SLC_CLASS_AB;
  // pin state: 3 ground, 2 low-r clamp, 1 high-r clamp, 0 open or driven.
  assign line_pin = line_ctrl.line_output_discharge ? 2'h3 :
                    line_ctrl.clamp_low_resistance  ? 2'h2 :
                    line_ctrl.clamp_high_resistance ? 2'h1 : 2'h0;
endmodule

// >>> test/tb_top.sv
// Self-checking bench for the speaker and line control register bank.
`timescale 1ns/1ps

module tb_top;
  import slc_pkg::*;
  logic              clock = 1'b0;
  logic              reset_n, reg_write, reg_read, reg_rdata_valid, flag;
  logic              line_output_enable, speaker_enable, class_ab;
  logic [7:0]        reg_addr, reg_wdata, reg_rdata;
  logic [2:0]        dc_level, ac_level;
  logic [1:0]        line_pin;
  slc_speaker_ctrl_t speaker_ctrl;
  slc_line_ctrl_t    line_ctrl;
  int                fail_count, n_tests;
  logic [7:0]        addr_t[4] = '{8'h04, 8'h08, 8'h09, 8'h0a};
  logic [7:0]        mask_t[4] = '{8'h20, 8'h07, 8'h3f, 8'h40};

  slc_regs DUT (.clock, .reset_n, .reg_write, .reg_read, .reg_addr, .reg_wdata,
    .reg_rdata, .reg_rdata_valid, .line_output_enable, .speaker_enable, .speaker_ctrl,
    .line_ctrl, .boost_write_while_enabled(flag));
  slc_analog_model u_far (.speaker_ctrl, .line_ctrl, .line_output_enable, .dc_level,
    .ac_level, .class_ab, .line_pin);

  always #2.5 clock = ~clock;

  task automatic end_of_test();
    if (fail_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Inputs always move one nanosecond after a rising edge.
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cyc(1);
    reg_write = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    cyc(1);
    reg_write = 1'b0;
  endtask

  // The answer wait is bounded so a silent bank cannot hang the run.
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    int i;
    cyc(1);
    reg_read = 1'b1;
    reg_addr = a;
    cyc(1);
    reg_read = 1'b0;
    for (i = 0; i < 4 && reg_rdata_valid !== 1'b1; i++) cyc(1);
    if (i == 4) begin
      fail_count++;
      end_of_test();
    end else begin
      chk(reg_rdata, e);
    end
  endtask

  initial begin
    {reset_n, reg_write, reg_read, reg_addr, reg_wdata} = '0;
    {line_output_enable, speaker_enable, fail_count, n_tests} = '0;
    cyc(4);
    reset_n = 1'b1;
    // Reset images, then an unmapped place and undescribed bits.
    rd(MIDRAIL_BUFFER_CONTROL_ADDR, 8'h00);
    rd(ANTIPOP_LINE_CONTROL_ADDR, 8'h00);
    rd(SPEAKER_BOOST_CONTROL_ADDR, 8'h1b);
    chk(8'(speaker_ctrl.speaker_ac_boost), 8'h08);
    rd(SPEAKER_CLASS_CONTROL_ADDR, 8'h00);
    chk(8'(line_pin), 8'h00);
    wr(8'h05, 8'hff);
    rd(8'h05, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wr(addr_t[k], 8'hff);
      rd(addr_t[k], mask_t[k]);
      wr(addr_t[k], 8'h00);
    end
    // Every code on both fields, reserved ones included.
    for (int c = 0; c < 8; c++) begin
      wr(SPEAKER_BOOST_CONTROL_ADDR, {2'h0, 3'(c), 3'(7 - c)});
      cyc(2);
      chk(8'(dc_level), c > 5 ? 8'h00 : 8'(c));
      chk(8'(ac_level), 7 - c > 5 ? 8'h00 : 8'(7 - c));
      chk(8'(speaker_ctrl.boost_code_reserved), 8'(c > 5 || c < 2));
    end
    // Boost change while the speaker plays is flagged, a rewrite is not.
    speaker_enable = 1'b1;
    // The flag stands only in the cycle after the write, so look at once.
    wr(SPEAKER_BOOST_CONTROL_ADDR, 8'h1b);
    chk(8'(flag), 8'h01);
    wr(SPEAKER_BOOST_CONTROL_ADDR, 8'h1b);
    chk(8'(flag), 8'h00);
    speaker_enable = 1'b0;
    wr(SPEAKER_CLASS_CONTROL_ADDR, 8'h40);
    cyc(2);
    chk(8'(class_ab), 8'h01);
    // Start-up order: discharge first, then reference and clamp.
    wr(ANTIPOP_LINE_CONTROL_ADDR, 8'h04);
    cyc(2);
    chk(8'(line_pin), 8'h03);
    wr(MIDRAIL_BUFFER_CONTROL_ADDR, 8'h20);
    wr(ANTIPOP_LINE_CONTROL_ADDR, 8'h01);
    cyc(2);
    chk(8'(line_pin), 8'h01);
    wr(ANTIPOP_LINE_CONTROL_ADDR, 8'h03);
    cyc(2);
    chk(8'(line_pin), 8'h02);
    line_output_enable = 1'b1;
    cyc(2);
    chk(8'(line_pin), 8'h00);
    line_output_enable = 1'b0;
    wr(MIDRAIL_BUFFER_CONTROL_ADDR, 8'h00);
    cyc(2);
    chk(8'(line_pin), 8'h00);
    wr(ANTIPOP_LINE_CONTROL_ADDR, 8'h04);
    cyc(2);
    chk(8'(line_pin), 8'h03);
    wr(ANTIPOP_LINE_CONTROL_ADDR, 8'h00);
    cyc(2);
    chk(8'(line_pin), 8'h00);
    // A second reset in mid-run restores the defaults.
    wr(SPEAKER_BOOST_CONTROL_ADDR, 8'h2c);
    reset_n = 1'b0;
    cyc(4);
    reset_n = 1'b1;
    rd(SPEAKER_BOOST_CONTROL_ADDR, 8'h1b);
    rd(SPEAKER_CLASS_CONTROL_ADDR, 8'h00);
    chk(8'(speaker_ctrl.speaker_dc_boost), 8'h08);
    end_of_test();
  end
endmodule
